// File: inc/isp_pkg.sv
// isp_pkg: constants and types for the programming command engine.
// assumes mclk at 25 MHz; the link clock arrives on a pin from the programmer.
package isp_pkg;
  localparam int MCLK_NS = 40;
  localparam int T_WR_NS = 2500000;   // write cycle, 2.5 ms
  localparam int T_AWR_NS = 5000000;  // write with auto-erase, 5 ms
  localparam int T_ERS_NS = 7500000;  // chip erase, 7.5 ms
  localparam int PAGE_BYTES = 128;
  localparam int HALF_BYTES = 64;
  localparam int OFS_W = 6;
  localparam int PAGE_W = 9;
  localparam int LAST_HDR = 2;        // index of the low address byte
  localparam logic [6:0] LAST_BYTE_IDX = 7'h03;
  localparam logic [6:0] LAST_PAGE_IDX = 7'h42;
  localparam logic [7:0] OP_MISC = 8'hac;
  localparam logic [7:0] AH_PROG_EN = 8'h53;
  localparam logic [7:0] AH_PAR_EN = 8'h35;
  localparam logic [2:0] AH_CHIP_ERASE = 3'h4;
  localparam logic [5:0] AH_LOCK_MODE = 6'h38;
  localparam logic [7:0] OP_STATUS = 8'h60;
  localparam logic [7:0] OP_RD_LOCK_MODE = 8'h24;
  localparam logic [7:0] OP_LOAD_BUF = 8'h4f;
  localparam logic [7:0] OP_DATA_WR_AE = 8'hd2;
  localparam logic [7:0] ENABLE_ACK = 8'h69;
  localparam logic [7:0] POLL_ERASED = 8'h7f;
  localparam logic [7:0] MSB_FLIP = 8'h80;
  localparam logic [7:0] BYTE_ERASED = 8'hff;
  localparam logic [7:0] BYTE_LOCKED = 8'h00;
  localparam logic [2:0] LOCK_RESET = 3'h0;
  localparam logic LOAD_RESET = 1'b1;
  localparam int ST_LOAD = 3;
  localparam int ST_SUCCESS = 2;
  localparam int ST_WRITE_INHIBITED_FLAG = 1;
  localparam int ST_READY = 0;
  typedef enum logic [2:0] {
    SP_NONE, SP_CODE, SP_DATA, SP_FUSE, SP_LOCK, SP_USIG, SP_ASIG
  } isp_space_t;
  typedef enum logic [1:0] {PS_IDLE, PS_ERASE, PS_WRITE, PS_WAIT} isp_pstate_t;
endpackage : isp_pkg

// File: design/isp_cmd_engine.sv
// isp_cmd_engine: target-side programming command engine with page buffer.
// assumes a nonvolatile array outside that answers nv_rdata combinationally
// from nv_addr/nv_space, and accepts nv_we and nv_erase strobes.
// Notes on behaviour
// - pages are 128 bytes; one command moves at most a 64-byte half page
// - write with auto-erase erases the whole 128-byte page first
// - fuses are one row, byte per fuse; chip erase leaves them alone
// - 00h enables a fuse; back to FFh needs an auto-erase row rewrite
// - lock bits are cleared by chip erase only
// - packet is opcode, two address bytes, then one or 64 data bytes
// - a command ends only when every packet byte has been shifted
// - page address: 6-bit offset, 1-bit half select, 9-bit page
// - offset increments per data byte, wraps inside the same half page
// - enable command AC 53 must come first; answers 69h in fourth byte
// - parallel enable AC 35 switches to byte transfers until session ends
// - code page ops: 50h write, 70h write auto-erase, 30h read
// - data page ops: D0h, D2h auto-erase, B0h read; high address ignored
// - fuse ops: 41h write one, 21h read one, 71h row write auto-erase
// - status bit 3 cleared by load-buffer command, set by next write
// - status bit 2 cleared at cycle start, set only if no brownout
// - bit 1 low during brownout; bit 0 low while busy or inhibited
// - polling read of last loaded byte gives MSB inverted while busy
// - during erase polling returns 7Fh
// - lock mode 2 refuses programming of every memory space except the lock bits
// - lock mode 3 also blocks code and data reads
// - serial link is mode 0, MSB first, link clock up to about 4 MHz (each phase over 3 mclk)
// - session lives only while the reset pin is held active
// - parallel: OE high takes bytes on rising edge, low drives reads
`timescale 1ns/100ps
module isp_cmd_engine
  import isp_pkg::*;
#(
  parameter int WR_CYCLES = (T_WR_NS + MCLK_NS - 1) / MCLK_NS,
  parameter int AWR_CYCLES = (T_AWR_NS + MCLK_NS - 1) / MCLK_NS,
  parameter int ERS_CYCLES = (T_ERS_NS + MCLK_NS - 1) / MCLK_NS,
  parameter logic [7:0] SIG_B0 = 8'h5a,  // identity bytes, values arbitrary
  parameter logic [7:0] SIG_B1 = 8'ha5,
  parameter logic [7:0] SIG_B2 = 8'h3c
) (
  input wire logic mclk,                  // system clock
  input wire logic srst,                  // synchronous reset, high
  input wire logic ce,                    // clock enable, freezes state when low
  input wire logic rst_pin,               // device reset pin, raw
  input wire logic reset_polarity_select, // 1: reset pin active high
  input wire logic sck,                   // link clock from programmer
  input wire logic mosi,                  // serial in; output enable low in parallel
  output logic miso_o,                    // serial out
  output logic miso_oe,                   // serial out drive enable
  input wire logic [7:0] p0_i,            // parallel port in
  output logic [7:0] p0_o,                // parallel port out
  output logic p0_oe,                     // parallel port drive enable
  input wire logic bod,                   // brownout, high inhibits writes
  output logic [15:0] nv_addr,            // array address {page,half,offset}
  output isp_space_t nv_space,            // array space
  input wire logic [7:0] nv_rdata,        // array read data
  output logic nv_we,                     // byte program strobe
  output logic [7:0] nv_wdata,            // byte program data
  output logic nv_erase,                  // erase strobe
  output logic nv_erase_all,              // erase whole space, not one page
  output logic [7:0] programming_status,  // status byte
  output logic write_inhibited_flag       // brownout inhibit, low active flag
);
  localparam int SW = 13;
  logic [SW-1:0] sync1_q, sync2_q;
  logic sck_s, mosi_s, rst_s, pol_s, bod_s, session, sck_d_q, rise, fall;
  logic [7:0] p0_s, byte_val, tx_q, tx_d, tx_sh_q, ah_q, op_q, rx_sh_q;
  logic [2:0] bit_cnt_q, lock_q;
  logic [6:0] byte_cnt_q;
  logic byte_done, last, enabled_q, par_q, load_q, start_q, busy, bod_hit_q;
  logic [OFS_W-1:0] ofs_q, last_ofs_q, p_idx_q, p_ofs_q;
  logic half_q, p_half_q, p_ae_q, p_chip_q, p_lock_mode_q, p_er_step_q, success_q;
  logic [PAGE_W-1:0] page_q, p_page_q;
  logic [7:0] last_data_q, p_data_q, p_bb_q;
  logic [7:0] buf_q [HALF_BYTES];
  logic [HALF_BYTES-1:0] mask_q;
  logic [31:0] tm_q;
  isp_space_t dec_space, p_space_q;
  logic dec_wr, dec_rd, dec_ae, dec_page, poll_hit, wr_block, rd_block;
  isp_pstate_t ps_q;

  // two flops on every pin input; only the second stage is read
  always_ff @(posedge mclk) begin
    if (srst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else if (ce) begin
      sync1_q <= {p0_i, bod, reset_polarity_select, rst_pin, mosi, sck};
      sync2_q <= sync1_q;
    end
  end
  assign sck_s = sync2_q[0];
  assign mosi_s = sync2_q[1];
  assign rst_s = sync2_q[2];
  assign pol_s = sync2_q[3];
  assign bod_s = sync2_q[4];
  assign p0_s = sync2_q[12:5];
  assign session = pol_s ? rst_s : ~rst_s;

  // link clock edges found by sampling
  always_ff @(posedge mclk) begin
    if (srst) begin
      sck_d_q <= 1'b0;
    end else if (ce) begin
      sck_d_q <= sck_s;
    end
  end
  assign rise = session & sck_s & ~sck_d_q;
  assign fall = session & ~sck_s & sck_d_q;

  // mode 0: sample on rise; parallel takes a whole byte each rise
  assign byte_done = rise & (par_q | (bit_cnt_q == 3'h7));
  assign byte_val = par_q ? (mosi_s ? p0_s : 8'h00) : {rx_sh_q[6:0], mosi_s};
  always_ff @(posedge mclk) begin
    if (srst || (ce && !session)) begin
      bit_cnt_q <= 3'h0;
      rx_sh_q <= 8'h00;
    end else if (ce && rise && !par_q) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      rx_sh_q <= {rx_sh_q[6:0], mosi_s};  // msb first
    end
  end

  // opcode decode into space and direction
  always_comb begin
    dec_space = SP_NONE;
    dec_wr = 1'b0;
    dec_rd = 1'b0;
    dec_ae = 1'b0;
    if (op_q[7]) begin
      if (op_q[3:0] == 4'h0 || op_q == OP_DATA_WR_AE) begin
        dec_space = SP_DATA;
        dec_wr = op_q[6];
        dec_rd = ~op_q[6];
        dec_ae = (op_q == OP_DATA_WR_AE);
      end
    end else if (op_q[6:5] != 2'b00 && op_q[7:4] != 4'h6) begin
      case (op_q[3:0])
        4'h0: dec_space = SP_CODE;
        4'h1: dec_space = SP_FUSE;
        4'h2: dec_space = SP_USIG;
        4'h4: dec_space = (op_q[6] & op_q[5]) ? SP_NONE : SP_LOCK;
        4'h8: dec_space = op_q[6] ? SP_NONE : SP_ASIG;
        default: dec_space = SP_NONE;
      endcase
      dec_wr = op_q[6];
      dec_rd = ~op_q[6];
      dec_ae = op_q[6] & op_q[5];
    end
  end
  assign dec_page = op_q[4];
  // packet length fixed by the opcode
  assign last = (byte_cnt_q == (dec_page ? LAST_PAGE_IDX : LAST_BYTE_IDX));
  assign wr_block = lock_q[0];
  assign rd_block = lock_q[0] & lock_q[1];
  assign busy = (ps_q != PS_IDLE);

  // packet assembly, page buffer and command execution
  always_ff @(posedge mclk) begin
    if (srst) begin
      byte_cnt_q <= 7'h00;
      op_q <= 8'h00;
      ah_q <= 8'h00;
      ofs_q <= '0;
      half_q <= 1'b0;
      page_q <= '0;
      enabled_q <= 1'b0;
      par_q <= 1'b0;
      load_q <= LOAD_RESET;
      start_q <= 1'b0;
      mask_q <= '0;
      last_data_q <= 8'h00;
      last_ofs_q <= '0;
    end else if (ce) begin
      start_q <= 1'b0;
      if (ps_q == PS_WAIT && tm_q == 32'h0) begin
        mask_q <= '0;  // buffer is spent once a cycle ends
      end
      if (!session) begin
        byte_cnt_q <= 7'h00;
        enabled_q <= 1'b0;
        par_q <= 1'b0;
      end else if (byte_done) begin
        if (byte_cnt_q == 7'h00) begin
          op_q <= byte_val;
        end else if (byte_cnt_q == 7'h01) begin
          ah_q <= byte_val;
        end else if (byte_cnt_q == 7'(LAST_HDR)) begin
          ofs_q <= byte_val[OFS_W-1:0];
          half_q <= byte_val[OFS_W];
          // only code space takes page bits from the high address byte
          page_q <= (dec_space == SP_CODE) ? {ah_q, byte_val[7]} : {8'h00, byte_val[7]};
        end else begin
          if ((dec_wr || op_q == OP_LOAD_BUF) && !busy) begin
            buf_q[ofs_q] <= byte_val;
            mask_q[ofs_q] <= 1'b1;
            last_data_q <= byte_val;
            last_ofs_q <= ofs_q;
          end
          ofs_q <= ofs_q + 1'b1;
        end
        // a command only acts after its final byte
        if (last) begin
          byte_cnt_q <= 7'h00;
          if (op_q == OP_MISC && ah_q == AH_PROG_EN) begin
            enabled_q <= 1'b1;
          end else if (enabled_q) begin
            if (op_q == OP_MISC && ah_q == AH_PAR_EN) begin
              par_q <= 1'b1;
            end else if (op_q == OP_LOAD_BUF) begin
              load_q <= 1'b0;
            end else if (op_q == OP_MISC && !busy && !bod_s &&
                         (ah_q[7:5] == AH_CHIP_ERASE || ah_q[7:2] == AH_LOCK_MODE)) begin
              start_q <= 1'b1;
            end else if (dec_wr && dec_space != SP_NONE && !busy && !bod_s &&
                         (!wr_block || dec_space == SP_LOCK)) begin
              start_q <= 1'b1;
              load_q <= 1'b1;
            end else if (dec_wr) begin
              mask_q <= '0;     // refused write leaves memory unchanged
            end
          end
        end else begin
          byte_cnt_q <= byte_cnt_q + 7'h01;
        end
      end
    end
  end

  // program sequencer: erase, byte writes, then timed wait
  always_ff @(posedge mclk) begin
    if (srst) begin
      ps_q <= PS_IDLE;
      tm_q <= 32'h0;
      p_idx_q <= '0;
      p_space_q <= SP_NONE;
      p_page_q <= '0;
      p_half_q <= 1'b0;
      p_ae_q <= 1'b0;
      p_chip_q <= 1'b0;
      p_lock_mode_q <= 1'b0;
      p_bb_q <= 8'h00;
      p_er_step_q <= 1'b0;
      p_ofs_q <= '0;
      p_data_q <= 8'h00;
      lock_q <= LOCK_RESET;
      success_q <= 1'b0;
      bod_hit_q <= 1'b0;
    end else if (ce) begin
      case (ps_q)
        PS_IDLE: begin
          if (start_q) begin
            success_q <= 1'b0;
            bod_hit_q <= 1'b0;
            p_chip_q <= (op_q == OP_MISC) && (ah_q[7:5] == AH_CHIP_ERASE);
            p_lock_mode_q <= (op_q == OP_MISC) && (ah_q[7:2] == AH_LOCK_MODE);
            p_bb_q <= ah_q;
            p_space_q <= (op_q == OP_MISC) ? SP_CODE : dec_space;
            p_page_q <= page_q;
            p_half_q <= half_q;
            p_ae_q <= dec_ae && op_q != OP_MISC;
            p_ofs_q <= last_ofs_q;
            p_data_q <= last_data_q;
            p_er_step_q <= 1'b0;
            p_idx_q <= '0;
            if (op_q == OP_MISC && ah_q[7:5] == AH_CHIP_ERASE) begin
              ps_q <= PS_ERASE;
              tm_q <= 32'(ERS_CYCLES - 1);
            end else if (dec_ae && op_q != OP_MISC) begin
              ps_q <= PS_ERASE;
              tm_q <= 32'(AWR_CYCLES - 1);
            end else begin
              ps_q <= PS_WRITE;
              tm_q <= 32'(WR_CYCLES - 1);
            end
          end
        end
        PS_ERASE: begin
          // chip erase walks code then data; fuses are never in that walk
          if (p_chip_q && !p_er_step_q) begin
            p_er_step_q <= 1'b1;
          end else if (p_chip_q) begin
            lock_q <= LOCK_RESET;
            ps_q <= PS_WAIT;
          end else begin
            ps_q <= PS_WRITE;
          end
        end
        PS_WRITE: begin
          p_idx_q <= p_idx_q + 1'b1;
          if (p_lock_mode_q) begin
            lock_q <= lock_q | {p_bb_q[1] & p_bb_q[0], p_bb_q[1], |p_bb_q[1:0]};
          end else if (p_space_q == SP_LOCK && mask_q[p_idx_q] &&
                       buf_q[p_idx_q] == BYTE_LOCKED && p_idx_q < OFS_W'(3)) begin
            lock_q[p_idx_q[1:0]] <= 1'b1;  // programming only adds locks
          end
          if (p_idx_q == OFS_W'(HALF_BYTES - 1) || p_lock_mode_q) begin
            ps_q <= PS_WAIT;
          end
        end
        PS_WAIT: begin
          if (tm_q == 32'h0) begin
            ps_q <= PS_IDLE;
            success_q <= ~bod_hit_q & ~bod_s;
          end
        end
        default: ps_q <= PS_IDLE;
      endcase
      if (ps_q != PS_IDLE && tm_q != 32'h0) begin
        tm_q <= tm_q - 32'h1;
      end
      if (ps_q != PS_IDLE && bod_s) begin
        bod_hit_q <= 1'b1;
      end
    end
  end

  // array strobes and shared address; writer wins while cycling
  always_ff @(posedge mclk) begin
    if (srst) begin
      nv_addr <= 16'h0000;
      nv_space <= SP_NONE;
      nv_we <= 1'b0;
      nv_wdata <= 8'h00;
      nv_erase <= 1'b0;
      nv_erase_all <= 1'b0;
    end else if (ce) begin
      nv_we <= 1'b0;
      nv_erase <= 1'b0;
      nv_erase_all <= 1'b0;
      if (ps_q == PS_ERASE) begin
        nv_erase <= 1'b1;  // whole 128-byte page, both halves
        nv_erase_all <= p_chip_q;
        nv_space <= p_chip_q ? (p_er_step_q ? SP_DATA : SP_CODE) : p_space_q;
        nv_addr <= {p_page_q, 1'b0, 6'h00};
      end else if (ps_q == PS_WRITE && !p_lock_mode_q && p_space_q != SP_LOCK) begin
        nv_we <= mask_q[p_idx_q];
        nv_wdata <= buf_q[p_idx_q];
        nv_space <= p_space_q;
        nv_addr <= {p_page_q, p_half_q, p_idx_q};
      end else begin
        nv_space <= dec_space;
        nv_addr <= {page_q, half_q, ofs_q};
      end
    end
  end

  // outgoing byte for the next packet position
  assign poll_hit = busy && dec_space == p_space_q &&
                    {page_q, half_q, ofs_q} == {p_page_q, p_half_q, p_ofs_q};
  always_comb begin
    tx_d = 8'h00;
    if (op_q == OP_MISC && ah_q == AH_PROG_EN) begin
      tx_d = ENABLE_ACK;
    end else if (op_q == OP_STATUS) begin
      tx_d = programming_status;
    end else if (op_q == OP_RD_LOCK_MODE) begin
      tx_d = {3'b000, ~lock_q, 2'b00};
    end else if (dec_rd) begin
      if (dec_space == SP_LOCK) begin
        tx_d = (ofs_q < OFS_W'(3) && lock_q[ofs_q[1:0]]) ? BYTE_LOCKED : BYTE_ERASED;
      end else if (dec_space == SP_ASIG) begin
        tx_d = (ofs_q == OFS_W'(0)) ? SIG_B0 : (ofs_q == OFS_W'(1)) ? SIG_B1 :
               (ofs_q == OFS_W'(2)) ? SIG_B2 : BYTE_ERASED;
      end else if (rd_block && (dec_space == SP_CODE || dec_space == SP_DATA)) begin
        tx_d = 8'h00;
      end else if (poll_hit && (ps_q == PS_ERASE || p_chip_q)) begin
        tx_d = POLL_ERASED;
      end else if (poll_hit) begin
        tx_d = p_data_q ^ MSB_FLIP;
      end else if (dec_space != SP_NONE) begin
        tx_d = nv_rdata;
      end
    end
  end

  // output shifting on the falling link edge
  always_ff @(posedge mclk) begin
    if (srst) begin
      tx_q <= 8'h00;
      tx_sh_q <= 8'h00;
      miso_o <= 1'b0;
      miso_oe <= 1'b0;
      p0_o <= 8'h00;
      p0_oe <= 1'b0;
    end else if (ce) begin
      tx_q <= tx_d;
      miso_oe <= session & ~par_q;
      p0_oe <= session & par_q & ~mosi_s;
      if (fall && par_q) begin
        p0_o <= tx_q;
      end else if (fall && bit_cnt_q == 3'h0) begin
        miso_o <= tx_q[7];
        tx_sh_q <= {tx_q[6:0], 1'b0};
      end else if (fall) begin
        miso_o <= tx_sh_q[7];
        tx_sh_q <= {tx_sh_q[6:0], 1'b0};
      end
    end
  end

  // status byte kept in a flop
  always_ff @(posedge mclk) begin
    if (srst) begin
      programming_status <= 8'h00;
      write_inhibited_flag <= 1'b0;
    end else if (ce) begin
      programming_status <= 8'h00;
      programming_status[ST_LOAD] <= load_q;
      programming_status[ST_SUCCESS] <= success_q;
      programming_status[ST_WRITE_INHIBITED_FLAG] <= ~bod_s;
      programming_status[ST_READY] <= ~(busy | bod_s);
      write_inhibited_flag <= ~bod_s;
    end
  end
endmodule : isp_cmd_engine

// File: sim/isp_cmd_engine_props.sv
// isp_cmd_engine_props: port checks for the programming command engine.
// assumes one mclk domain and srst synchronous active high.
`timescale 1ns/100ps
module isp_cmd_engine_props
  import isp_pkg::*;
(
  input wire logic mclk, // clock
  input wire logic srst, // reset
  input wire logic rst_pin, // session pin
  input wire logic reset_polarity_select, // pin level
  input wire logic sck, // link clock
  input wire logic bod, // brownout
  input wire logic miso_o, // serial out
  input wire logic miso_oe, // serial drive
  input wire logic p0_oe, // parallel drive
  input wire logic nv_we, // program strobe
  input wire logic nv_erase, // erase strobe
  input wire logic nv_erase_all, // erase space
  input wire logic [15:0] nv_addr, // address
  input wire logic [7:0] programming_status, // status
  input wire logic write_inhibited_flag // inhibit
);
  wire logic rdy = programming_status[ST_READY];
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // pins pass two sync flops and a register, so allow some margin
  sequence s_off;
    (rst_pin != reset_polarity_select)[*5];
  endsequence
  sequence s_bod;
    bod[*6];
  endsequence
  AST_SESSION_OFF: assert property (s_off |-> !miso_oe && !p0_oe)
    else $error("link driven outside session");
  AST_BOD_INHIBIT: assert property (s_bod |-> !write_inhibited_flag)
    else $error("brownout not flagged");
  AST_INH_NOT_READY: assert property (!programming_status[ST_WRITE_INHIBITED_FLAG] |-> !rdy)
    else $error("ready while inhibited");
  AST_WE_BUSY: assert property (nv_we |=> !rdy)
    else $error("program strobe while ready");
  AST_ERASE_PAGE: assert property (nv_erase && !nv_erase_all |-> !(|nv_addr[6:0]))
    else $error("page erase not page aligned");
  AST_LINK_EXCL: assert property (!(miso_oe && p0_oe))
    else $error("serial and parallel both driven");
  AST_MISO_HOLD: assert property (
    $changed(miso_o) && $past(miso_oe) |-> !$past(sck) && !$past(sck, 2))
    else $error("serial out moved while clock high");
  AST_LOAD_AFTER_RST: assert property ($fell(srst) |=> programming_status[7:3] == 5'h01)
    else $error("status wrong after reset");
endmodule : isp_cmd_engine_props

bind isp_cmd_engine isp_cmd_engine_props i_isp_cmd_engine_props (
  .mclk, .srst, .rst_pin, .reset_polarity_select, .sck, .bod, .miso_o, .miso_oe, .p0_oe,
  .nv_we, .nv_erase, .nv_erase_all, .nv_addr, .programming_status, .write_inhibited_flag);

// File: sim/isp_prog_model.sv
// isp_prog_model: behavioural programmer, master of the serial link.
// assumes the bench keeps the device reset pin active during a session.
`timescale 1ns/100ps
module isp_prog_model (
  output logic sck, // link clock
  output logic mosi, // data to device
  input wire logic miso_o, // data from device
  input wire logic miso_oe // device drives miso
);
  logic miso_q = 1'b0;
  logic miso_w;
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
  end
  // no pull on the wire: an undriven line shows its last level inverted
  assign miso_w = miso_oe ? miso_o : ~miso_q;
  // one byte in mode 0, msb first; clock stands low between bytes
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      #160;
      sck = 1'b1;
      rx[i] = miso_w;
      miso_q = miso_w;
      #160;
      sck = 1'b0;
    end
  endtask : xfer
  // park or steer the data line; in parallel mode it is the output enable
  task automatic drive_line(input logic v);
    mosi = v;
  endtask : drive_line
  // one link clock period with nothing shifted; parallel bytes ride on the port
  task automatic pulse();
    #160;
    sck = 1'b1;
    #160;
    sck = 1'b0;
  endtask : pulse
endmodule : isp_prog_model

// File: sim/isp_cmd_engine_tb.sv
// isp_cmd_engine_tb: directed bench for the programming command engine.
// assumes isp_prog_model as link master and a small array model here.
`timescale 1ns/100ps
module isp_cmd_engine_tb
  import isp_pkg::*;
;
  localparam logic [7:0] WR_OP [3] = '{8'hd0, 8'hd2, 8'h70};
  localparam logic [7:0] RD_OP [3] = '{8'hb0, 8'hb0, 8'h30};
  localparam logic [7:0] LO_B [3] = '{8'h40, 8'h00, 8'h00};
  localparam logic [7:0] HI_B [3] = '{8'ha5, 8'h5a, 8'h00};
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic rst_pin = 1'b0;
  logic bod = 1'b0;
  logic ce = 1'b1;
  logic reset_polarity_select = 1'b1;  // reset pin active high in this bench
  logic [7:0] p0_i = 8'h00;
  logic sck, mosi, miso_o, miso_oe, p0_oe, nv_we, nv_erase, nv_erase_all, write_inhibited_flag;
  logic [7:0] p0_o, nv_rdata, nv_wdata, programming_status, rx;
  logic [15:0] nv_addr;
  isp_space_t nv_space;
  logic [7:0] mem [0:2047];
  logic [7:0] dat [0:63];
  int err_count = 0;
  int checks_done = 0;
  always #20 mclk = ~mclk;
  // short cycle counts keep the run brief
  isp_cmd_engine #(.WR_CYCLES(2000), .AWR_CYCLES(3000), .ERS_CYCLES(4000)) i_isp_cmd_engine (
    .mclk, .srst, .ce, .rst_pin, .reset_polarity_select, .sck, .mosi, .miso_o,
    .miso_oe, .p0_i, .p0_o, .p0_oe, .bod, .nv_addr, .nv_space, .nv_rdata, .nv_we,
    .nv_wdata, .nv_erase, .nv_erase_all, .programming_status, .write_inhibited_flag);
  isp_prog_model i_isp_prog_model (.sck, .mosi, .miso_o, .miso_oe);
  // array answers at once; erase fills a 128-byte page or a space with ff
  assign nv_rdata = mem[{nv_space, nv_addr[7:0]}];
  always @(posedge mclk) begin
    if (nv_we) mem[{nv_space, nv_addr[7:0]}] <= nv_wdata;
    for (int i = 0; i < 256; i++) begin
      if (nv_erase && (nv_erase_all || i[7] == nv_addr[7])) mem[{nv_space, i[7:0]}] <= 8'hff;
    end
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish
  // whole four-byte packet; rx keeps the answer of the last byte
  task automatic cmd(input logic [7:0] op, input logic [7:0] hi, input logic [7:0] lo);
    logic [7:0] r;
    i_isp_prog_model.xfer(op, r);
    i_isp_prog_model.xfer(hi, r);
    i_isp_prog_model.xfer(lo, r);
    i_isp_prog_model.xfer(8'h00, rx);
  endtask : cmd
  // page packet: every one of the 64 bytes is sent, replies land in dat
  task automatic page(input logic [7:0] op, input logic [7:0] hi, input logic [7:0] lo);
    logic [7:0] r;
    i_isp_prog_model.xfer(op, r);
    i_isp_prog_model.xfer(hi, r);
    i_isp_prog_model.xfer(lo, r);
    for (int k = 0; k < 64; k++) i_isp_prog_model.xfer(dat[k], dat[k]);
  endtask : page
  // bounded wait for ready; running out counts and ends the run
  task automatic wait_ready();
    int n;
    n = 0;
    // busy shows only a few clocks after the last link edge, so let it appear first
    repeat (8) @(posedge mclk);
    #5;
    while (programming_status[ST_READY] !== 1'b1) begin
      @(posedge mclk);
      #5;
      n++;
      if (n > 20000) begin
        err_count++;
        tally_and_finish();
      end
    end
  endtask : wait_ready
  initial begin
    for (int i = 0; i < 2048; i++) mem[i] = 8'hff;
    repeat (10) @(posedge mclk);
    #5 srst = 1'b0;
    repeat (4) @(posedge mclk);
    #5 check("reset status", programming_status, 8'h0b);
    rst_pin = 1'b1; // held active for the whole session
    repeat (4) @(posedge mclk);
    #5 cmd(8'hac, 8'h53, 8'h00); // enable comes first
    check("enable answer", rx, 8'h69);
    cmd(8'h60, 8'h00, 8'h00);
    check("status read", rx, 8'h0b);
    // start at offset 5 of the upper half so the run wraps; no byte loaded twice
    for (int k = 0; k < 64; k++) dat[k] = 8'(k * 7 + 1);
    page(8'h50, 8'h00, 8'h45);
    cmd(8'h20, 8'h00, 8'h44);
    check("poll busy", rx, 8'(63 * 7 + 1) ^ 8'h80);
    wait_ready();
    check("status done", programming_status, 8'h0f);
    page(8'h30, 8'h00, 8'h40);
    for (int k = 0; k < 64; k++) check("wrapped page", dat[k], 8'(((k + 59) % 64) * 7 + 1));
    // data page, data with erase, code with erase; erase must clear the other half
    for (int s = 0; s < 3; s++) begin
      for (int k = 0; k < 64; k++) dat[k] = 8'(k + s * 64);
      page(WR_OP[s], HI_B[s], LO_B[s]);
      repeat (4) @(posedge mclk);
      #5 check("status busy", programming_status, 8'h0a);
      wait_ready();
      page(RD_OP[s], 8'h00, LO_B[s]);
      for (int k = 0; k < 64; k++) check("page data", dat[k], 8'(k + s * 64));
      if (s > 0) begin
        page(RD_OP[s], 8'h00, LO_B[s] ^ 8'h40);
        for (int k = 0; k < 64; k++) check("erased half", dat[k], 8'hff);
      end
    end
    // fuse values are only 00 or ff
    cmd(8'h41, 8'h00, 8'h03);
    wait_ready();
    cmd(8'h21, 8'h00, 8'h03);
    check("fuse set", rx, 8'h00);
    for (int k = 0; k < 64; k++) dat[k] = (k == 5) ? 8'h00 : 8'hff;
    page(8'h71, 8'h00, 8'h00);
    wait_ready();
    cmd(8'h21, 8'h00, 8'h03);
    check("fuse restored", rx, 8'hff);
    cmd(8'hac, 8'he2, 8'h00); // lock mode 3
    wait_ready();
    cmd(8'h20, 8'h00, 8'h44);
    check("locked read", rx, 8'h00);
    cmd(8'h41, 8'h00, 8'h03); // refused while locked
    wait_ready();
    cmd(8'h21, 8'h00, 8'h03);
    check("locked fuse", rx, 8'hff);
    cmd(8'hac, 8'h80, 8'h00);
    cmd(8'h20, 8'h00, 8'h03);
    check("erase poll", rx, 8'h7f);
    wait_ready();
    cmd(8'h20, 8'h00, 8'h44);
    check("erased unlocked", rx, 8'hff);
    cmd(8'h21, 8'h00, 8'h05);
    check("fuse kept", rx, 8'h00);
    bod = 1'b1;
    repeat (8) @(posedge mclk);
    #5 check("brownout status", programming_status, 8'h0c);
    bod = 1'b0;
    repeat (8) @(posedge mclk);
    #5 cmd(8'hac, 8'h35, 8'h00);
    // status read over the port: three bytes in with enable high, one out with it low
    i_isp_prog_model.drive_line(1'b1);
    for (int k = 0; k < 4; k++) begin
      p0_i = (k == 0) ? 8'h60 : 8'h00;
      if (k == 3) i_isp_prog_model.drive_line(1'b0);
      i_isp_prog_model.pulse();
    end
    repeat (6) @(posedge mclk);
    #5 check("parallel status", p0_o, 8'h0f);
    @(posedge mclk);
    #5 i_isp_prog_model.drive_line(1'b0); // output enable low asks for read bytes
    repeat (6) @(posedge mclk);
    #5 check("parallel drive", {6'h00, p0_oe, miso_oe}, 8'h02);
    rst_pin = 1'b0;
    repeat (6) @(posedge mclk);
    #5 check("session closed", {6'h00, p0_oe, miso_oe}, 8'h00);
    tally_and_finish();
  end
endmodule : isp_cmd_engine_tb
